// [logic/mcfg_pkg.sv]
/*
  Package for the memory configuration register and chip-select decode.
  Assumes a single 50 MHz clock domain and a plain register port.
*/
package mcfg_pkg;
  // ==========================================================
  // Register map
  localparam logic [31:0] MCFG_ADDR_CFG   = 32'h01f80010;
  // ==========================================================
  // Field positions
  localparam int MCFG_BCNT_LSB  = 0;
  localparam int MCFG_SP0_SEL   = 2;
  localparam int MCFG_SP0_LSB   = 3;
  localparam int MCFG_SP1_SEL   = 6;
  localparam int MCFG_SP1_LSB   = 7;
  localparam int MCFG_RAM_SIZE_LSB  = 10;
  localparam int MCFG_RPAR      = 13;
  localparam int MCFG_REDAC     = 14;
  localparam int MCFG_PWR       = 16;
  localparam int MCFG_P8        = 17;
  localparam int MCFG_PROM_SIZE_LSB  = 18;
  localparam int MCFG_EXCHANGE_MEM_SIZE_LSB  = 24;
  localparam int MCFG_EPAR      = 27;
  localparam int MCFG_EEDAC     = 28;
  localparam int MCFG_EEX       = 29;
  // ==========================================================
  // Writable bits and reset value (bit 17 comes from the pin)
  localparam logic [31:0] MCFG_WR_MASK  = 32'h3f1d7fff;
  localparam logic [31:0] MCFG_RST_VAL  = 32'h00010000;
  // ==========================================================
  // Size bases, in bytes, and RAM bank count
  localparam logic [31:0] MCFG_RAM_BASE  = 32'h00040000;
  localparam logic [31:0] MCFG_PROM_BASE = 32'h00020000;
  localparam logic [31:0] MCFG_XCH_BASE  = 32'h00001000;
  localparam int          MCFG_NBANK     = 8;
endpackage : mcfg_pkg

// [logic/mcfg_top.sv]
/*
  Memory configuration register with RAM bank chip-select decode,
  spare bank substitution, size decode and protection enables.
  Assumes synchronous inputs, one clock, and a register master that
  never issues read and write strobes together.
*/
module mcfg_top (
  input  wire logic        i_clk,             // 50 MHz clock
  input  wire logic        i_rst,             // Async reset, active high
  input  wire logic [31:0] i_addr,            // Register byte address
  input  wire logic [31:0] i_wdata,           // Write data
  input  wire logic        i_wr,              // Write strobe
  input  wire logic        i_rd,              // Read strobe
  output logic      [31:0] o_rdata,           // Read data, cycle after strobe
  input  wire logic        i_prom_width_pin,  // Strap: 1 is 40-bit PROM
  input  wire logic        i_prom_write_strap,// External PROM write allowed
  input  wire logic        i_parity_check_inhibit, // Skip parity checks
  input  wire logic        i_ram_req,         // RAM access request
  input  wire logic [2:0]  i_ram_bank,        // Bank addressed
  output logic      [9:0]  o_ram_bank_select, // Chip selects, 8/9 are spares
  output logic      [31:0] o_ram_size,        // RAM bank size in bytes
  output logic      [31:0] o_prom_size,       // PROM size in bytes
  output logic      [31:0] o_exchange_size,   // Exchange size in bytes
  output logic             o_ram_par_chk,     // Check RAM parity
  output logic             o_ram_edac,        // RAM EDAC on
  output logic             o_xch_par_chk,     // Check exchange parity
  output logic             o_xch_edac,        // Exchange EDAC on
  output logic             o_exchange_present,// Exchange memory present
  output logic             o_prom_write_ok,   // PROM writes allowed
  output logic             o_prom_wide        // 40-bit PROM with EDAC
);
  import mcfg_pkg::*;

  // ==========================================================
  // Register storage
  logic [31:0] cfg_q;
  logic        p8_q;
  logic        p8_load_q;
  logic [31:0] rdata_q;
  logic [9:0]  cs_q;
  logic [31:0] rsz_q;
  logic [31:0] psz_q;
  logic [31:0] esz_q;
  logic        rpc_q;
  logic        red_q;
  logic        xpc_q;
  logic        xed_q;
  logic        xpr_q;
  logic        pwo_q;
  logic        pw_q;

  wire         sel_cfg  = (i_addr == MCFG_ADDR_CFG);
  wire         wr_cfg   = i_wr & sel_cfg;
  wire  [31:0] cfg_d    = wr_cfg ? (i_wdata & MCFG_WR_MASK) : cfg_q;
  wire  [31:0] cfg_view = cfg_q | ({31'h0, p8_q} << MCFG_P8);
  wire  [31:0] rdata_d  = (i_rd & sel_cfg) ? cfg_view : 32'h0;

  // ==========================================================
  // Field decode
  wire  [1:0]  bank_cnt  = cfg_q[MCFG_BCNT_LSB +: 2];
  wire         sp0_sel   = cfg_q[MCFG_SP0_SEL];
  wire  [2:0]  sp0_tgt   = cfg_q[MCFG_SP0_LSB +: 3];
  wire         sp1_sel   = cfg_q[MCFG_SP1_SEL];
  wire  [2:0]  sp1_tgt   = cfg_q[MCFG_SP1_LSB +: 3];

  wire  [7:0]  bank_en   = (bank_cnt == 2'h0) ? 8'h01 :
                           (bank_cnt == 2'h1) ? 8'h03 :
                           (bank_cnt == 2'h2) ? 8'h0f : 8'hff;
  wire         sp0_hit   = sp0_sel & (i_ram_bank == sp0_tgt);
  // spare 1 blocked on equal targets
  wire         sp1_ok    = sp1_sel & (sp1_tgt != sp0_tgt);
  wire         sp1_hit   = sp1_ok & (i_ram_bank == sp1_tgt);
  wire  [7:0]  bank_hot;
  wire  [9:0]  cs_d;

  genvar g;
  generate
    for (g = 0; g < MCFG_NBANK; g++) begin : g_bank
      assign bank_hot[g] = (i_ram_bank == 3'(g)) & bank_en[g];
    end
  endgenerate

  assign cs_d = i_ram_req ?
                {sp1_hit, sp0_hit, (sp0_hit | sp1_hit) ? 8'h00 : bank_hot} : 10'h0;

  wire  [31:0] rsz_d = MCFG_RAM_BASE  << cfg_q[MCFG_RAM_SIZE_LSB +: 3];
  wire  [31:0] psz_d = MCFG_PROM_BASE << cfg_q[MCFG_PROM_SIZE_LSB +: 3];
  wire  [31:0] esz_d = MCFG_XCH_BASE  << cfg_q[MCFG_EXCHANGE_MEM_SIZE_LSB +: 3];
  wire         rpc_d = (cfg_q[MCFG_RPAR] | cfg_q[MCFG_REDAC]) & ~i_parity_check_inhibit;
  wire         xpc_d = (cfg_q[MCFG_EPAR] | cfg_q[MCFG_EEDAC]) & ~i_parity_check_inhibit;
  wire         pwo_d = cfg_q[MCFG_PWR] & i_prom_write_strap;
  wire         red_d = cfg_q[MCFG_REDAC];
  wire         xed_d = cfg_q[MCFG_EEDAC];
  wire         xpr_d = cfg_q[MCFG_EEX];
  wire         pw_d  = p8_q;

  // ==========================================================
  // Flops
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_q     <= MCFG_RST_VAL;
      rdata_q   <= 32'h0;
    end else begin
      cfg_q     <= cfg_d;
      rdata_q   <= rdata_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      p8_q      <= 1'b0;
      p8_load_q <= 1'b1;
    end else begin
      p8_load_q <= 1'b0;
      if (p8_load_q) begin
        p8_q    <= i_prom_width_pin;
      end
    end
  end

  // ==========================================================
  // Select and output flops
  // registered selects
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_q  <= 10'h0;
    end else begin
      cs_q  <= cs_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rsz_q <= 32'h0;
      psz_q <= 32'h0;
      esz_q <= 32'h0;
    end else begin
      rsz_q <= rsz_d;
      psz_q <= psz_d;
      esz_q <= esz_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rpc_q <= 1'b0;
      red_q <= 1'b0;
      xpc_q <= 1'b0;
      xed_q <= 1'b0;
      xpr_q <= 1'b0;
      pwo_q <= 1'b0;
      pw_q  <= 1'b0;
    end else begin
      rpc_q <= rpc_d;
      red_q <= red_d;
      xpc_q <= xpc_d;
      xed_q <= xed_d;
      xpr_q <= xpr_d;
      pwo_q <= pwo_d;
      pw_q  <= pw_d;
    end
  end

  // ==========================================================
  // Output drive
  assign o_rdata            = rdata_q;
  assign o_ram_bank_select  = cs_q;
  assign o_ram_size         = rsz_q;
  assign o_prom_size        = psz_q;
  assign o_exchange_size    = esz_q;
  assign o_ram_par_chk      = rpc_q;
  assign o_ram_edac         = red_q;
  assign o_xch_par_chk      = xpc_q;
  assign o_xch_edac         = xed_q;
  assign o_exchange_present = xpr_q;
  assign o_prom_write_ok    = pwo_q;
  assign o_prom_wide        = pw_q;

  // ==========================================================
  // Assertions
  a_bank_range: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ram_req && bank_cnt == 2'h0 && i_ram_bank != 3'h0 && !sp0_hit && !sp1_hit
    |=> o_ram_bank_select == 10'h0)
    else $error("bank beyond count selected");
  a_spare0_sub: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ram_req && sp0_hit |=> o_ram_bank_select == 10'h100)
    else $error("spare 0 not substituted");
  a_spare1_sub: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ram_req && sp1_hit && !sp0_hit |=> o_ram_bank_select == 10'h200)
    else $error("spare 1 not substituted");
  a_spare_tie: assert property (@(posedge i_clk) disable iff (i_rst)
    sp0_tgt == sp1_tgt |=> !o_ram_bank_select[9])
    else $error("spare 1 active on equal targets");
  a_ram_size: assert property (@(posedge i_clk) disable iff (i_rst)
    cfg_q[12:10] == 3'h7 |=> o_ram_size == 32'h02000000)
    else $error("ram size decode wrong");
  a_edac_par: assert property (@(posedge i_clk) disable iff (i_rst)
    cfg_q[MCFG_REDAC] && !i_parity_check_inhibit |=> o_ram_par_chk)
    else $error("edac without parity");
  a_par_inhibit: assert property (@(posedge i_clk) disable iff (i_rst)
    i_parity_check_inhibit |=> !o_ram_par_chk && !o_xch_par_chk)
    else $error("parity checked while inhibited");
  a_prom_wr: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_prom_write_strap |=> !o_prom_write_ok)
    else $error("prom write without strap");
  a_resv_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rd |=> (o_rdata & 32'hc0e08000) == 32'h0)
    else $error("reserved bits nonzero");
  a_flag_ro: assert property (@(posedge i_clk) disable iff (i_rst)
    !p8_load_q ##1 wr_cfg |=> $stable(p8_q))
    else $error("width flag changed by write");
  a_xch_size: assert property (@(posedge i_clk) disable iff (i_rst)
    cfg_q[26:24] == 3'h0 |=> o_exchange_size == 32'h00001000)
    else $error("exchange size decode wrong");

  // ==========================================================
  // Chip select checks
  a_bank_onehot: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ram_req && ({1'b0, i_ram_bank} < (4'h1 << bank_cnt)) && !sp0_hit && !sp1_hit
    |=> o_ram_bank_select == (10'h001 << $past(i_ram_bank)))
    else $error("enabled bank not selected");
  a_bank_idle: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_ram_req |=> o_ram_bank_select == 10'h0)
    else $error("select without request");
  a_bank_upper: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ram_req && bank_cnt != 2'h3 && i_ram_bank[2] && !sp0_hit && !sp1_hit
    |=> o_ram_bank_select == 10'h0)
    else $error("upper bank selected below full count");
  a_spare0_off: assert property (@(posedge i_clk) disable iff (i_rst)
    !sp0_sel |=> !o_ram_bank_select[8])
    else $error("spare 0 used while off");
  a_spare1_off: assert property (@(posedge i_clk) disable iff (i_rst)
    !sp1_sel |=> !o_ram_bank_select[9])
    else $error("spare 1 used while off");
  a_sel_onehot: assert property (@(posedge i_clk) disable iff (i_rst)
    $onehot0(o_ram_bank_select))
    else $error("two selects active");

  // ==========================================================
  // Size checks
  // every size code
  for (genvar k = 0; k < 8; k++) begin : g_size_chk
    a_ram_code: assert property (@(posedge i_clk) disable iff (i_rst)
      cfg_q[12:10] == 3'(k) |=> o_ram_size == (32'h00040000 << k))
      else $error("ram size code wrong");
    a_prom_code: assert property (@(posedge i_clk) disable iff (i_rst)
      cfg_q[20:18] == 3'(k) |=> o_prom_size == (32'h00020000 << k))
      else $error("prom size code wrong");
    a_xch_code: assert property (@(posedge i_clk) disable iff (i_rst)
      cfg_q[26:24] == 3'(k) |=> o_exchange_size == (32'h00001000 << k))
      else $error("exchange size code wrong");
  end
  a_new_size: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_cfg |=> ##1 o_ram_size == (32'h00040000 << $past(i_wdata[12:10], 2)))
    else $error("new ram size not applied");

  // ==========================================================
  // Protection checks
  a_ram_par_on: assert property (@(posedge i_clk) disable iff (i_rst)
    cfg_q[MCFG_RPAR] && !i_parity_check_inhibit |=> o_ram_par_chk)
    else $error("ram parity not checked");
  a_ram_par_off: assert property (@(posedge i_clk) disable iff (i_rst)
    !cfg_q[MCFG_RPAR] && !cfg_q[MCFG_REDAC] |=> !o_ram_par_chk)
    else $error("ram parity checked while off");
  a_ram_edac_out: assert property (@(posedge i_clk) disable iff (i_rst)
    o_ram_edac == $past(cfg_q[MCFG_REDAC]))
    else $error("ram edac output wrong");
  a_xch_par_on: assert property (@(posedge i_clk) disable iff (i_rst)
    cfg_q[MCFG_EPAR] && !i_parity_check_inhibit |=> o_xch_par_chk)
    else $error("exchange parity not checked");
  a_xch_par_off: assert property (@(posedge i_clk) disable iff (i_rst)
    !cfg_q[MCFG_EPAR] && !cfg_q[MCFG_EEDAC] |=> !o_xch_par_chk)
    else $error("exchange parity checked while off");
  a_xch_edac_par: assert property (@(posedge i_clk) disable iff (i_rst)
    cfg_q[MCFG_EEDAC] && !i_parity_check_inhibit |=> o_xch_par_chk)
    else $error("exchange edac without parity");
  a_xch_edac_out: assert property (@(posedge i_clk) disable iff (i_rst)
    o_xch_edac == $past(cfg_q[MCFG_EEDAC]))
    else $error("exchange edac output wrong");
  a_xch_present: assert property (@(posedge i_clk) disable iff (i_rst)
    o_exchange_present == $past(cfg_q[MCFG_EEX]))
    else $error("exchange presence wrong");
  a_prom_wr_on: assert property (@(posedge i_clk) disable iff (i_rst)
    cfg_q[MCFG_PWR] && i_prom_write_strap |=> o_prom_write_ok)
    else $error("prom write refused");
  a_prom_wr_off: assert property (@(posedge i_clk) disable iff (i_rst)
    !cfg_q[MCFG_PWR] |=> !o_prom_write_ok)
    else $error("prom write while disabled");

  // ==========================================================
  // Register checks
  a_prom_wide: assert property (@(posedge i_clk) disable iff (i_rst)
    !p8_load_q |=> o_prom_wide == $past(p8_q))
    else $error("prom width output wrong");
  a_pin_load: assert property (@(posedge i_clk) disable iff (i_rst)
    p8_load_q && !i_rst |=> p8_q == $past(i_prom_width_pin))
    else $error("width flag not loaded from pin");
  a_flag_view: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rd && sel_cfg && !p8_load_q |=> o_rdata[MCFG_P8] == p8_q)
    else $error("width flag read wrong");
  a_flag_nostore: assert property (@(posedge i_clk) disable iff (i_rst)
    !cfg_q[MCFG_P8])
    else $error("width flag stored from write");
  a_resv_store: assert property (@(posedge i_clk) disable iff (i_rst)
    (cfg_q & 32'hc0e08000) == 32'h0)
    else $error("reserved bits stored");
  a_cfg_write: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_cfg |=> cfg_q == ($past(i_wdata) & 32'h3f1d7fff))
    else $error("register write wrong");
  a_cfg_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    !wr_cfg |=> $stable(cfg_q))
    else $error("register changed without write");
  a_rd_unmapped: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rd && !sel_cfg |=> o_rdata == 32'h0)
    else $error("unmapped read nonzero");

  // ==========================================================
  // Cover points
  c_spare0: cover property (@(posedge i_clk) disable iff (i_rst) o_ram_bank_select[8]);
  c_spare1: cover property (@(posedge i_clk) disable iff (i_rst) o_ram_bank_select[9]);
  c_all_banks: cover property (@(posedge i_clk) disable iff (i_rst) o_ram_bank_select[7]);
  c_cfg_read: cover property (@(posedge i_clk) disable iff (i_rst) i_rd && sel_cfg);
  c_spare_tie: cover property (@(posedge i_clk) disable iff (i_rst)
    i_ram_req && sp0_sel && sp1_sel && sp0_tgt == sp1_tgt);
endmodule // mcfg_top

// [tb/mcfg_mem_model.sv]
/*
  Memory chips on the select side; also drives the parity inhibit pin.
  Assumes selects are sampled on rising clock edges.
*/
module mcfg_mem_model (
  input  wire logic       i_clk,   // Clock
  input  wire logic [9:0] i_sel,   // Chip selects
  input  wire logic       i_inh,   // Inhibit request from bench
  output logic            o_inh,   // Parity inhibit pin
  output int              o_multi  // Count of multi-select cycles
);
  timeunit 1ns;
  timeprecision 1ps;
  assign o_inh = i_inh;
  int multi_q = 0;
  assign o_multi = multi_q;
  // Two chips must never be selected together
  always @(posedge i_clk)
    if (!$onehot0(i_sel)) multi_q <= multi_q + 1;
endmodule // mcfg_mem_model

// [tb/test_memory_config_chip_select.sv]
/*
  Self-checking bench for the memory configuration register.
  Assumes mcfg_pkg and the memory model are compiled first.
*/
module test_memory_config_chip_select;
  timeunit 1ns;
  timeprecision 1ps;
  import mcfg_pkg::*;
  logic        clk, rst, wr, rd, pin, strap, inh_cmd, inh, req;
  logic [31:0] addr, wdata, rdata, rs, ps, xs, cfg, r;
  logic [31:0] lfsr = 32'h2032;
  logic [2:0]  bank;
  logic [9:0]  sel;
  logic        rpar, redac, xpar, xedac, xpres, pwok, pwide;
  int          fail_count, samples_checked, multi;

  mcfg_top i_mcfg_top (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_prom_width_pin(pin),
    .i_prom_write_strap(strap), .i_parity_check_inhibit(inh), .i_ram_req(req),
    .i_ram_bank(bank), .o_ram_bank_select(sel), .o_ram_size(rs), .o_prom_size(ps),
    .o_exchange_size(xs), .o_ram_par_chk(rpar), .o_ram_edac(redac),
    .o_xch_par_chk(xpar), .o_xch_edac(xedac), .o_exchange_present(xpres),
    .o_prom_write_ok(pwok), .o_prom_wide(pwide));
  mcfg_mem_model i_mcfg_mem_model (.i_clk(clk), .i_sel(sel), .i_inh(inh_cmd),
    .o_inh(inh), .o_multi(multi));

  // ==========================================================
  // Helpers
  function logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function logic [9:0] exp_sel(logic [31:0] c, logic [2:0] b);
    int n;
    n = 1 << c[1:0];
    if (c[2] && c[5:3] == b) return 10'h100;
    if (c[6] && c[9:7] == b && c[9:7] != c[5:3]) return 10'h200;
    return (b < n) ? (10'h001 << b) : 10'h000;
  endfunction
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task wrr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk); wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk); wr <= 1'b0;
  endtask
  task rdc(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk); rd <= 1'b1; addr <= a;
    @(posedge clk); rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  task acc(input logic [2:0] b);
    @(posedge clk); req <= 1'b1; bank <= b;
    @(posedge clk); req <= 1'b0;
    #1 chk("select", {22'h0, exp_sel(cfg, b)}, {22'h0, sel});
  endtask
  task outs();
    chk("ram_size", MCFG_RAM_BASE << cfg[12:10], rs);
    chk("prom_size", MCFG_PROM_BASE << cfg[20:18], ps);
    chk("xch_size", MCFG_XCH_BASE << cfg[26:24], xs);
    chk("ram_par", {31'h0, (cfg[13] | cfg[14]) & ~inh}, {31'h0, rpar});
    chk("ram_edac", {31'h0, cfg[14]}, {31'h0, redac});
    chk("xch_par", {31'h0, (cfg[27] | cfg[28]) & ~inh}, {31'h0, xpar});
    chk("xch_edac", {31'h0, cfg[28]}, {31'h0, xedac});
    chk("present", {31'h0, cfg[29]}, {31'h0, xpres});
    chk("prom_wr", {31'h0, cfg[16] & strap}, {31'h0, pwok});
    chk("wide", {31'h0, pin}, {31'h0, pwide});
    rdc(MCFG_ADDR_CFG, (cfg & ~32'hc0e28000) | ({31'h0, pin} << 17));
  endtask
  task setcfg(input logic [31:0] d);
    wrr(MCFG_ADDR_CFG, d);
    cfg = d;
    @(posedge clk);
    #1 outs();
  endtask
  task test_done();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================
  // Stimulus
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = '0; wdata = '0; pin = 1'b1;
    strap = 1'b1; inh_cmd = 1'b0; req = 1'b0; bank = '0; cfg = MCFG_RST_VAL;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1 outs();
    rdc(32'h01f80014, 32'h0);
    wrr(32'h01f80014, 32'hffffffff);
    rdc(MCFG_ADDR_CFG, MCFG_RST_VAL | 32'h00020000);
    // Every bank count code, then equal spare targets
    for (int c = 0; c < 5; c++) begin
      setcfg((c < 4) ? c : 32'h000001df);
      for (int b = 0; b < 8; b++) acc(3'(b));
    end
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      @(posedge clk); strap <= r[31]; inh_cmd <= r[30];
      setcfg(rnd());
      for (int k = 0; k < 4; k++) begin
        r = rnd();
        acc(r[2:0]);
      end
    end
    // Reset again with the strap pin low
    @(posedge clk); pin <= 1'b0; rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cfg = MCFG_RST_VAL;
    repeat (2) @(posedge clk);
    #1 outs();
    chk("multi_sel", 32'h0, multi);
    test_done();
  end
  initial begin
    #(20 * 20000);
    fail_count++;
    test_done();
  end
endmodule // test_memory_config_chip_select
